// ### rtl/dpid_debounce.sv
`timescale 1ns/100ps
module dpid_debounce (
	input wire logic i_core_clk, // Core clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_ce, // Clock enable
	input wire logic i_tick, // 1 us tick pulse
	input wire logic i_enable, // Filter on
	input wire logic [15:0] i_period, // Stable ticks required
	input wire logic [7:0] i_raw, // Synchronised inputs
	output logic [7:0] o_filtered // Filtered inputs
);

	// ----------------------------------------------------------------
	// Per-bit stability counters
	// ----------------------------------------------------------------
	genvar gb;
	generate
		for (gb = 0; gb < dpid_pkg::PORT_W; gb++)
		begin : g_bit
			logic [15:0] stab_q;
			// Restart the count on every bounce, accept once stable
			always_ff @(posedge i_core_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					stab_q <= 16'h0000;
					o_filtered[gb] <= 1'b0;
				end
				else if (i_ce)
				begin
					if (i_raw[gb] == o_filtered[gb])
					begin
						stab_q <= 16'h0000;
					end
					else if (!i_enable || stab_q >= i_period)
					begin
						o_filtered[gb] <= i_raw[gb];
						stab_q <= 16'h0000;
					end
					else if (i_tick)
					begin
						stab_q <= stab_q + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// Bypass when off: the raw level shows one cycle later
	a_filter_bypass : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_ce && !i_enable) |=> (o_filtered == $past(i_raw)))
		else $error("filter off but output did not follow input");

endmodule : dpid_debounce

// ### rtl/dpid_pkg.sv
package dpid_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 8;
	localparam int CH_W = 64;
	localparam int FILT_PORTS = 2;
	localparam int NUM_CNT = 2;
	localparam int CNT_W = 16;
	localparam int MODE_W = 3;
	localparam int PEND_W = 17;
	localparam int TIMER_BIT = 16;

	// ----------------------------------------------------------------
	// Interrupt mode byte fields
	// ----------------------------------------------------------------
	localparam int CFG_EDGE_P0 = 0;
	localparam int CFG_EN_P0 = 1;
	localparam int CFG_EDGE_P1 = 2;
	localparam int CFG_EN_P1 = 3;
	localparam int CFG_EN_TMR = 4;
	localparam int CFG_USED_W = 5;

	// ----------------------------------------------------------------
	// Offsets, codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CLEAR_OFFSET = 8'hd0;
	localparam logic [MODE_W-1:0] MODE_STOP = 3'h5;
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [CH_W-1:0] OUT_RESET = 64'h0000_0000_0000_0000;

	// ----------------------------------------------------------------
	// Timing: 1 us filter and counter tick
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 7;

endpackage : dpid_pkg

// ### rtl/dpid_top.sv
`timescale 1ns/100ps
module dpid_top (
	input wire logic i_core_clk, // Core clock, 125 MHz
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_ce, // Clock enable, freezes state when low
	input wire logic [63:0] i_io_channel, // Channel pin levels
	output logic [63:0] o_io_channel, // Channel pin drive levels
	output logic [63:0] o_io_channel_oe_n, // Low while driving the pin
	input wire logic i_port_wr, // Write a whole output port
	input wire logic i_bit_set, // Drive one channel high
	input wire logic i_bit_reset, // Drive one channel low
	input wire logic [2:0] i_port_select, // Port for writes
	input wire logic [2:0] i_bit_select, // Bit for set and reset
	input wire logic [7:0] i_port_data, // Port write data
	input wire logic i_direction_wr, // Load direction byte
	input wire logic [7:0] i_port_direction_byte, // 1 = input port
	input wire logic i_debounce_wr, // Load debounce enables
	input wire logic [1:0] i_debounce_enable, // Filter enable, ports 1:0
	input wire logic i_period_wr, // Load filter period
	input wire logic [15:0] i_filter_period, // Filter period in ticks
	input wire logic i_counter_wr, // Load counter mode and value
	input wire logic i_counter_select, // 0 = counter 1, 1 = counter 2
	input wire logic [2:0] i_counter_mode, // Work mode 0 to 5
	input wire logic [15:0] i_counter_value, // Initial count
	input wire logic i_irq_config_wr, // Load interrupt mode byte
	input wire logic [7:0] i_irq_config_byte, // Interrupt mode byte
	input wire logic i_irq_disable, // Drop port interrupt enables
	input wire logic i_reg_wr, // Register write strobe
	input wire logic [7:0] i_reg_addr, // Register write offset
	output logic [63:0] o_io_input_word, // Channel input levels
	output logic [7:0] o_port_direction_byte, // Direction readback
	output logic [2:0] o_counter_mode, // Selected counter mode
	output logic [15:0] o_counter_value, // Selected counter count
	output logic [7:0] o_irq_config_byte, // Interrupt mode readback
	output logic [16:0] o_irq_pending_word, // Pending interrupt word
	output logic o_timer_irq_flag, // Timer pending
	output logic [7:0] o_low_port_irq_byte, // Port 0 pending
	output logic [7:0] o_second_port_irq_byte, // Port 1 pending
	output logic o_irq // Interrupt request, active high
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [63:0] sync1_q;
	logic [63:0] sync2_q;
	logic [63:0] out_q;
	logic [7:0] dir_q;
	logic [1:0] dbn_en_q;
	logic [15:0] period_q;
	logic [7:0] cfg_q;
	logic [16:0] pend_q;
	logic [16:0] pend_d;
	logic [16:0] irq_mask;
	logic [15:0] filt_w;
	logic [15:0] prev_q;
	logic [16:0] ev_w;
	logic [6:0] presc_q;
	logic tick_q;
	logic clear_w;
	logic [5:0] ch_idx;
	logic [2:0] mode_q [dpid_pkg::NUM_CNT];
	logic [15:0] cnt_q [dpid_pkg::NUM_CNT];
	logic [15:0] init_q [dpid_pkg::NUM_CNT];
	logic [dpid_pkg::NUM_CNT-1:0] cnt_evt;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	// ----------------------------------------------------------------
	// Pin input synchroniser
	// ----------------------------------------------------------------
	// Pins are asynchronous; only the second stage is read
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_q <= 64'h0000_0000_0000_0000;
			sync2_q <= 64'h0000_0000_0000_0000;
		end
		else if (i_ce)
		begin
			sync1_q <= i_io_channel;
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Microsecond tick
	// ----------------------------------------------------------------
	// Shared by filters and counters to keep one prescaler
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			presc_q <= 7'h00;
			tick_q <= 1'b0;
		end
		else if (i_ce)
		begin
			tick_q <= (presc_q == 7'(dpid_pkg::TICK_CYCLES - 1));
			if (presc_q == 7'(dpid_pkg::TICK_CYCLES - 1))
				presc_q <= 7'h00;
			else
				presc_q <= presc_q + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Output latch and direction
	// ----------------------------------------------------------------
	assign ch_idx = {i_port_select, i_bit_select};

	// Port write first, then bit set, then bit reset
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			out_q <= dpid_pkg::OUT_RESET;
		else if (i_ce)
		begin
			if (i_port_wr)
				out_q[{i_port_select, 3'h0} +: 8] <= i_port_data;
			else if (i_bit_set)
				out_q[ch_idx] <= 1'b1;
			else if (i_bit_reset)
				out_q[ch_idx] <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			dir_q <= dpid_pkg::DIR_RESET;
		else if (i_ce && i_direction_wr)
			dir_q <= i_port_direction_byte;
	end

	assign o_io_channel = out_q;
	assign o_port_direction_byte = dir_q;

	// Input ports never drive, so the pins start released
	genvar gp;
	generate
		for (gp = 0; gp < dpid_pkg::NUM_PORTS; gp++)
		begin : g_dir
			assign o_io_channel_oe_n[gp*8 +: 8] = {8{dir_q[gp]}};
		end
	endgenerate

	// ----------------------------------------------------------------
	// Debounce of ports 0 and 1
	// ----------------------------------------------------------------
	// filter settings
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			dbn_en_q <= 2'h0;
			period_q <= 16'h0000;
		end
		else if (i_ce)
		begin
			if (i_debounce_wr)
				dbn_en_q <= i_debounce_enable;
			if (i_period_wr)
				period_q <= i_filter_period;
		end
	end

	generate
		for (gp = 0; gp < dpid_pkg::FILT_PORTS; gp++)
		begin : g_filt
			dpid_debounce u_filt (
				.i_core_clk(i_core_clk),
				.i_rst_n(i_rst_n),
				.i_ce(i_ce),
				.i_tick(tick_q),
				.i_enable(dbn_en_q[gp]),
				.i_period(period_q),
				.i_raw(sync2_q[gp*8 +: 8]),
				.o_filtered(filt_w[gp*8 +: 8])
			);
		end
	endgenerate

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_io_input_word <= 64'h0000_0000_0000_0000;
		else if (i_ce)
			o_io_input_word <= {sync2_q[63:16], filt_w};
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	genvar gc;
	generate
		for (gc = 0; gc < dpid_pkg::NUM_CNT; gc++)
		begin : g_cnt
			// modes above 4 do not count
			assign cnt_evt[gc] = tick_q && (mode_q[gc] < dpid_pkg::MODE_STOP)
				&& (cnt_q[gc] == 16'h0000);

			// load mode and count, reload on expiry
			always_ff @(posedge i_core_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					mode_q[gc] <= dpid_pkg::MODE_STOP;
					cnt_q[gc] <= 16'h0000;
					init_q[gc] <= 16'h0000;
				end
				else if (i_ce)
				begin
					if (i_counter_wr && i_counter_select == 1'(gc))
					begin
						mode_q[gc] <= i_counter_mode;
						init_q[gc] <= i_counter_value;
						cnt_q[gc] <= i_counter_value;
					end
					else if (cnt_evt[gc])
						cnt_q[gc] <= init_q[gc];
					else if (tick_q && mode_q[gc] < dpid_pkg::MODE_STOP)
						cnt_q[gc] <= cnt_q[gc] - 16'h0001;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_counter_mode <= dpid_pkg::MODE_STOP;
			o_counter_value <= 16'h0000;
		end
		else if (i_ce)
		begin
			o_counter_mode <= mode_q[i_counter_select];
			o_counter_value <= cnt_q[i_counter_select];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt mode byte
	// ----------------------------------------------------------------
	// top bits kept at zero
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cfg_q <= dpid_pkg::CFG_RESET;
		else if (i_ce)
		begin
			if (i_irq_disable)
			begin
				cfg_q[dpid_pkg::CFG_EN_P0] <= 1'b0;
				cfg_q[dpid_pkg::CFG_EN_P1] <= 1'b0;
			end
			else if (i_irq_config_wr)
				cfg_q <= {3'h0, i_irq_config_byte[dpid_pkg::CFG_USED_W-1:0]};
		end
	end

	assign o_irq_config_byte = cfg_q;

	// ----------------------------------------------------------------
	// Edge events and pending word
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			prev_q <= 16'h0000;
		else if (i_ce)
			prev_q <= filt_w;
	end

	generate
		for (gp = 0; gp < dpid_pkg::FILT_PORTS; gp++)
		begin : g_edge
			localparam int EB = (gp == 0) ? dpid_pkg::CFG_EDGE_P0 : dpid_pkg::CFG_EDGE_P1;
			localparam int NB = (gp == 0) ? dpid_pkg::CFG_EN_P0 : dpid_pkg::CFG_EN_P1;
			assign ev_w[gp*8 +: 8] = {8{cfg_q[NB]}} & (cfg_q[EB]
				? (prev_q[gp*8 +: 8] & ~filt_w[gp*8 +: 8])
				: (~prev_q[gp*8 +: 8] & filt_w[gp*8 +: 8]));
		end
	endgenerate

	// timer event gated by bit 4
	assign ev_w[dpid_pkg::TIMER_BIT] = cfg_q[dpid_pkg::CFG_EN_TMR] && (|cnt_evt);

	// any data at the clear offset clears
	assign clear_w = i_reg_wr && (i_reg_addr == dpid_pkg::CLEAR_OFFSET);

	// sticky, a same-cycle event beats the clear
	assign pend_d = (pend_q & ~{dpid_pkg::PEND_W{clear_w}}) | ev_w;

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			pend_q <= 17'h0_0000;
		else if (i_ce)
			pend_q <= pend_d;
	end

	assign irq_mask = {cfg_q[dpid_pkg::CFG_EN_TMR], {8{cfg_q[dpid_pkg::CFG_EN_P1]}},
		{8{cfg_q[dpid_pkg::CFG_EN_P0]}}};

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else if (i_ce)
			o_irq <= |(pend_q & irq_mask);
	end

	// three-field view of the same flops
	assign o_irq_pending_word = pend_q;
	assign o_timer_irq_flag = pend_q[dpid_pkg::TIMER_BIT];
	assign o_low_port_irq_byte = pend_q[7:0];
	assign o_second_port_irq_byte = pend_q[15:8];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_clear_write;
		i_ce && i_reg_wr && (i_reg_addr == dpid_pkg::CLEAR_OFFSET);
	endsequence

	sequence s_quiet;
		ev_w == 17'h0_0000;
	endsequence

	a_bit_set_only : assert property ((i_ce && i_bit_set && !i_port_wr) |=>
		(out_q == ($past(out_q) | (64'h0000_0000_0000_0001 << $past(ch_idx)))))
		else $error("bit set touched other channels");

	a_bit_reset_only : assert property ((i_ce && i_bit_reset && !i_bit_set && !i_port_wr) |=>
		(out_q == ($past(out_q) & ~(64'h0000_0000_0000_0001 << $past(ch_idx)))))
		else $error("bit reset touched other channels");

	a_cfg_load : assert property ((i_ce && i_irq_config_wr && !i_irq_disable) |=>
		(cfg_q == {3'h0, $past(i_irq_config_byte[4:0])}))
		else $error("interrupt mode byte load wrong");

	a_disable_ports : assert property ((i_ce && i_irq_disable) |=>
		(!cfg_q[dpid_pkg::CFG_EN_P0] && !cfg_q[dpid_pkg::CFG_EN_P1] && !o_irq_config_byte[1]))
		else $error("disable left port interrupts on");

	a_stop_holds : assert property ((i_ce && mode_q[0] == dpid_pkg::MODE_STOP
		&& !i_counter_wr) |=> (cnt_q[0] == $past(cnt_q[0])))
		else $error("stopped counter moved");

	a_clear_any : assert property ((s_clear_write and s_quiet) |=>
		(o_irq_pending_word == 17'h0_0000))
		else $error("clear write did not clear status");

	a_set_wins : assert property ((s_clear_write and ev_w[dpid_pkg::TIMER_BIT]) |=>
		o_timer_irq_flag)
		else $error("event lost under clear");

	a_rise_event : assert property ((i_ce && cfg_q[1] && !cfg_q[0] && !prev_q[0] && filt_w[0])
		|=> o_low_port_irq_byte[0])
		else $error("rising edge on channel 0 not flagged");

	a_fall_port1 : assert property ((i_ce && cfg_q[3] && cfg_q[2] && prev_q[8] && !filt_w[8])
		|=> o_second_port_irq_byte[0])
		else $error("falling edge on channel 8 not flagged");

	a_irq_follows : assert property ((i_ce && |(pend_q & irq_mask)) |=> o_irq)
		else $error("interrupt request missing while pending");

endmodule : dpid_top

// ### verification/dpid_field_lines.sv
`timescale 1ns/100ps
// Field wiring model: drives input ports, listens on output ports
module dpid_field_lines (
	input wire logic [63:0] i_drive, // Card drive levels
	input wire logic [63:0] i_drive_oe_n, // Low where the card drives
	input wire logic [63:0] i_field, // Levels set by the field side
	output logic [63:0] o_pin // Resolved wire levels
);
	// ----------------------------------------------------------------
	// Wire resolution
	// ----------------------------------------------------------------
	// Field releases a line the card drives, so no contention is modelled
	// direction picks driver
	always_comb
	begin
		for (int k = 0; k < 64; k++)
		begin
			o_pin[k] = i_drive_oe_n[k] ? i_field[k] : i_drive[k];
		end
	end
endmodule : dpid_field_lines

// ### verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	typedef struct {int kind; logic [63:0] exp;} dpid_note_type;
	localparam int S_PW = 0, S_SET = 1, S_RST = 2, S_DIR = 3, S_DEB = 4;
	localparam int S_PER = 5, S_CNT = 6, S_CFG = 7, S_DIS = 8, S_REG = 9;
	logic i_core_clk, i_rst_n, i_ce, i_counter_select;
	logic [9:0] stb;
	logic [2:0] i_port_select, i_bit_select, i_counter_mode;
	logic [7:0] i_port_data, i_port_direction_byte, i_irq_config_byte, i_reg_addr, d;
	logic [1:0] i_debounce_enable;
	logic [15:0] i_filter_period, i_counter_value;
	logic [63:0] field, pin, exp_out, o_io_channel, o_io_channel_oe_n, o_io_input_word;
	logic [7:0] o_port_direction_byte, o_irq_config_byte, o_low_port_irq_byte;
	logic [7:0] o_second_port_irq_byte, dir_q;
	logic [2:0] o_counter_mode;
	logic [15:0] o_counter_value;
	logic [16:0] o_irq_pending_word;
	logic o_timer_irq_flag, o_irq;
	int fails, check_count, b;
	dpid_note_type notes[$];
	event noted;

	// ----------------------------------------------------------------
	// Clock, far side and device
	// ----------------------------------------------------------------
	initial
	begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end
	dpid_field_lines u_field (.i_drive(o_io_channel), .i_drive_oe_n(o_io_channel_oe_n),
		.i_field(field), .o_pin(pin));
	dpid_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_io_channel(pin), .o_io_channel(o_io_channel),
		.o_io_channel_oe_n(o_io_channel_oe_n), .i_port_wr(stb[S_PW]),
		.i_bit_set(stb[S_SET]), .i_bit_reset(stb[S_RST]), .i_port_select(i_port_select),
		.i_bit_select(i_bit_select), .i_port_data(i_port_data),
		.i_direction_wr(stb[S_DIR]), .i_port_direction_byte(i_port_direction_byte),
		.i_debounce_wr(stb[S_DEB]), .i_debounce_enable(i_debounce_enable),
		.i_period_wr(stb[S_PER]), .i_filter_period(i_filter_period),
		.i_counter_wr(stb[S_CNT]), .i_counter_select(i_counter_select),
		.i_counter_mode(i_counter_mode), .i_counter_value(i_counter_value),
		.i_irq_config_wr(stb[S_CFG]), .i_irq_config_byte(i_irq_config_byte),
		.i_irq_disable(stb[S_DIS]), .i_reg_wr(stb[S_REG]), .i_reg_addr(i_reg_addr),
		.o_io_input_word(o_io_input_word), .o_port_direction_byte(o_port_direction_byte),
		.o_counter_mode(o_counter_mode), .o_counter_value(o_counter_value),
		.o_irq_config_byte(o_irq_config_byte), .o_irq_pending_word(o_irq_pending_word),
		.o_timer_irq_flag(o_timer_irq_flag), .o_low_port_irq_byte(o_low_port_irq_byte),
		.o_second_port_irq_byte(o_second_port_irq_byte), .o_irq(o_irq));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : cyc

	// Strobe held across exactly one taking edge
	task automatic req(input int s);
		@(posedge i_core_clk);
		#1 stb[s] = 1'b1;
		@(posedge i_core_clk);
		#1 stb = '0;
	endtask : req

	task automatic note(input int kind, input logic [63:0] exp);
		notes.push_back('{kind, exp});
		->noted;
	endtask : note

	task automatic cmp(input logic [63:0] exp, input logic [63:0] act);
		check_count++;
		if (act !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t exp=%h act=%h", $time, exp, act);
		end
	endtask : cmp

	function automatic logic [63:0] act(input int k);
		case (k)
			0: return o_io_channel;
			1: return o_io_channel_oe_n;
			2: return 64'(o_port_direction_byte);
			3: return 64'(o_irq_config_byte);
			4: return 64'(o_irq_pending_word);
			5: return 64'(o_irq);
			6: return 64'({o_counter_mode, o_counter_value});
			7: return o_io_input_word;
			default: return 64'({o_timer_irq_flag, o_second_port_irq_byte, o_low_port_irq_byte});
		endcase
	endfunction : act

	// Expected wire levels: field on input ports, latch on output ports
	function automatic logic [63:0] pins(input logic oe);
		logic [63:0] p;
		for (int k = 0; k < 64; k++)
		begin
			p[k] = dir_q[k / 8] ? (oe ? 1'b1 : field[k]) : (oe ? 1'b0 : exp_out[k]);
		end
		return p;
	endfunction : pins

	task automatic clear_pending();
		i_reg_addr = 8'hd0;
		req(S_REG);
		cyc(2);
	endtask : clear_pending

	task automatic give_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// Monitor: drain notes oldest first against the outputs as they stand now
	initial
	begin : monitor
		dpid_note_type n;
		forever
		begin
			@(noted);
			while (notes.size() != 0)
			begin
				n = notes.pop_front();
				cmp(n.exp, act(n.kind));
			end
		end
	end

	// Watchdog well beyond the expected run of some 2000 cycles
	initial
	begin
		#400_000;
		fails++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{i_rst_n, stb, i_port_select, i_bit_select, i_port_data, i_counter_select} = '0;
		{i_port_direction_byte, i_irq_config_byte, i_reg_addr, i_debounce_enable} = '0;
		{i_filter_period, i_counter_mode, i_counter_value, field, exp_out} = '0;
		i_ce = 1'b1;
		dir_q = 8'hff;
		void'($urandom(32'h0039d9c2));
		repeat (12) @(posedge i_core_clk);
		#1 i_rst_n = 1'b1;
		cyc(1);
		note(0, 64'h0);
		note(1, pins(1'b1));
		note(2, 64'h0000_00ff);
		note(3, 64'h0);
		note(6, 64'h0005_0000);
		// Direction: random byte, then ports 0 and 1 input only
		d = 8'($urandom);
		i_port_direction_byte = d;
		req(S_DIR);
		dir_q = d;
		note(2, 64'(d));
		note(1, pins(1'b1));
		i_port_direction_byte = 8'h03;
		req(S_DIR);
		dir_q = 8'h03;
		// Port writes with one bit set then cleared, every port
		for (int p = 0; p < 8; p++)
		begin
			i_port_select = 3'(p);
			i_port_data = 8'($urandom);
			req(S_PW);
			exp_out[p*8 +: 8] = i_port_data;
			b = $urandom % 8;
			i_bit_select = 3'(b);
			req(S_SET);
			exp_out[p*8 + b] = 1'b1;
			note(0, exp_out);
			req(S_RST);
			exp_out[p*8 + b] = 1'b0;
			note(0, exp_out);
		end
		// Held clock enable refuses a set
		i_ce = 1'b0;
		req(S_SET);
		i_ce = 1'b1;
		note(0, exp_out);
		cyc(8);
		note(7, pins(1'b0));
		// Port 0 rising edges enabled
		i_irq_config_byte = 8'h02;
		req(S_CFG);
		field[3] = 1'b1;
		cyc(8);
		note(4, 64'h0000_0008);
		note(8, 64'h0000_0008);
		note(5, 64'h1);
		field[3] = 1'b0;
		i_reg_addr = 8'hd1;
		req(S_REG);
		cyc(8);
		note(4, 64'h0000_0008);
		clear_pending();
		note(4, 64'h0);
		note(5, 64'h0);
		// Port 1 falling only, port 0 blocked
		i_irq_config_byte = 8'h0c;
		req(S_CFG);
		field[10] = 1'b1;
		cyc(8);
		note(4, 64'h0);
		field[10] = 1'b0;
		field[2] = 1'b1;
		cyc(8);
		note(4, 64'h0000_0400);
		note(8, 64'h0000_0400);
		note(4, 64'h0000_0400);
		clear_pending();
		// Upper bits forced to zero, disable drops port enables
		i_irq_config_byte = 8'hff;
		req(S_CFG);
		note(3, 64'h0000_001f);
		req(S_DIS);
		note(3, 64'h0000_0015);
		field[4] = 1'b1;
		cyc(4);
		field[4] = 1'b0;
		cyc(8);
		note(4, 64'h0);
		// Filter on port 0 only, period 3 ticks
		i_filter_period = 16'h0003;
		req(S_PER);
		i_debounce_enable = 2'b01;
		req(S_DEB);
		field[0] = 1'b1;
		field[9] = 1'b1;
		cyc(100);
		note(7, pins(1'b0) & ~64'h1);
		field[0] = 1'b0;
		cyc(150);
		note(7, pins(1'b0));
		field[0] = 1'b1;
		cyc(700);
		note(7, pins(1'b0));
		// Counter 1 load, then stop with mode 5; readback trails by one cycle
		i_counter_mode = 3'h0;
		i_counter_value = 16'h000a;
		req(S_CNT);
		cyc(1);
		note(6, 64'h0000_000a);
		i_counter_mode = 3'h5;
		i_counter_value = 16'h0007;
		req(S_CNT);
		cyc(300);
		note(6, 64'h0005_0007);
		// Counter 2 expiry raises the timer bit
		i_irq_config_byte = 8'h10;
		req(S_CFG);
		i_counter_select = 1'b1;
		i_counter_mode = 3'h4;
		i_counter_value = 16'h0002;
		req(S_CNT);
		cyc(600);
		note(4, 64'h0001_0000);
		note(8, 64'h0001_0000);
		note(5, 64'h1);
		i_counter_mode = 3'h5;
		i_counter_value = 16'($urandom);
		req(S_CNT);
		cyc(1);
		note(6, {45'h0, 3'h5, i_counter_value});
		clear_pending();
		note(4, 64'h0);
		cyc(4);
		give_verdict();
	end
endmodule : tb_top
